// >>> ckd_pkg.sv
// Package for the clock divider, PLL and RC trim register block.
// Assumes a 32-bit APB master; registers hold 16 bits in the low lanes.
`default_nettype none
package ckd_pkg;
  // ==========================================================
  // Register map (word aligned byte addresses)
  localparam logic [11:0] ADDR_DIV_CTRL = 12'h000;
  localparam logic [11:0] ADDR_PLLFB    = 12'h004;
  localparam logic [11:0] ADDR_TRIM     = 12'h008;

  // ==========================================================
  // Implemented-bit masks
  localparam logic [15:0] MASK_DIV_CTRL = 16'hFFDF;
  localparam logic [15:0] MASK_PLLFB    = 16'h01FF;
  localparam logic [15:0] MASK_TRIM     = 16'h003F;

  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_DIV_CTRL = 16'h0040;
  localparam logic [15:0] RST_PLLFB    = 16'h0030;
  localparam logic [15:0] RST_TRIM     = 16'h0000;

  // ==========================================================
  // Field positions in the clock divider, feedback and trim registers
  localparam int RECOVER_BIT   = 15;
  localparam int RATIO_MSB     = 14;
  localparam int RATIO_LSB     = 12;
  localparam int REDUCE_EN_BIT = 11;
  localparam int RCPOST_MSB    = 10;
  localparam int RCPOST_LSB    = 8;
  localparam int POST_MSB      = 7;
  localparam int POST_LSB      = 6;
  localparam int PRE_MSB       = 4;
  localparam int PRE_LSB       = 0;
  localparam int FB_MSB        = 8;
  localparam int TRIM_MSB      = 5;

  // ==========================================================
  // Divider encodings
  localparam logic [1:0] POST_DIV2     = 2'h0;
  localparam logic [1:0] POST_DIV4     = 2'h1;
  localparam logic [1:0] POST_RESERVED = 2'h2;
  localparam logic [1:0] POST_DIV8     = 2'h3;
  localparam logic [3:0] POST_VAL2     = 4'h2;
  localparam logic [3:0] POST_VAL4     = 4'h4;
  localparam logic [3:0] POST_VAL8     = 4'h8;
  localparam logic [3:0] POST_INVALID  = 4'h0;
  localparam logic [5:0] PRE_OFFSET    = 6'h02;
  localparam logic [9:0] FB_OFFSET     = 10'h002;
  localparam logic [7:0] DIV_ONE       = 8'h01;
endpackage

`default_nettype wire

// >>> ckd_regs.sv
// Clock divider, PLL divider/multiplier and RC trim registers.
// Assumes an APB master on core_clk and an interrupt pulse from logic on the same clock.
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// - Interrupt with recover set clears reduction enable
// - Reduction ratio code selects power-of-two divisor
// - Disabled reduction forces ratio to 1:1
// - RC postscaler divides by two to the code
// - Input divider equals code plus two
// - Multiplier equals code plus two, reset 50
// - Feedback register bits 15..9 read zero
// - Trim register bits 15..6 read zero
// - Trim is signed, 0.375 percent per step
// - Zero trim is centre, all ones one step down
module ckd_regs (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  // Interrupt event from the interrupt controller
  input  wire logic        irq_event,
  // Clock generator controls
  output var  logic        recover_on_interrupt,
  output var  logic        reduction_enable,
  output var  logic [2:0]  cpu_clock_reduction_ratio,
  output var  logic [7:0]  cpu_divisor,
  output var  logic [2:0]  internal_rc_postscaler,
  output var  logic [7:0]  rc_post_divisor,
  output var  logic [1:0]  pll_output_divider,
  output var  logic [3:0]  postscale_factor,
  output var  logic [4:0]  pll_input_divider,
  output var  logic [5:0]  prescale_factor,
  output var  logic [8:0]  pll_feedback_divisor,
  output var  logic [9:0]  pll_multiplier,
  output var  logic [5:0]  rc_trim_code
);

  // ==========================================================
  // Bus decode
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        hit_div;
  logic        hit_fb;
  logic        hit_trim;

  assign setup    = psel && !penable;
  assign access   = psel && penable && pready;
  assign wr_en    = access && pwrite;
  assign hit_div  = paddr == ckd_pkg::ADDR_DIV_CTRL;
  assign hit_fb   = paddr == ckd_pkg::ADDR_PLLFB;
  assign hit_trim = paddr == ckd_pkg::ADDR_TRIM;

  // ==========================================================
  // Register storage
  logic [15:0] div_q, div_d;
  logic [15:0] fb_q, fb_d;
  logic [15:0] trim_q, trim_d;
  logic [2:0]  eff_ratio;

  always_comb begin
    div_d  = div_q;
    fb_d   = fb_q;
    trim_d = trim_q;
    // Only implemented bits take write data
    if (wr_en && hit_div) begin
      div_d = pwdata[15:0] & ckd_pkg::MASK_DIV_CTRL;
    end
    if (wr_en && hit_fb) begin
      fb_d = pwdata[15:0] & ckd_pkg::MASK_PLLFB;
    end
    if (wr_en && hit_trim) begin
      trim_d = pwdata[15:0] & ckd_pkg::MASK_TRIM;
    end
    // Recovery beats a same-cycle software write unless that write clears the recover bit
    if (irq_event && div_d[ckd_pkg::RECOVER_BIT]) begin
      div_d[ckd_pkg::REDUCE_EN_BIT] = 1'b0;
    end
  end

  // Disabled reduction means ratio code 0, i.e. 1:1
  assign eff_ratio = div_d[ckd_pkg::REDUCE_EN_BIT] ?
                     div_d[ckd_pkg::RATIO_MSB:ckd_pkg::RATIO_LSB] : 3'h0;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      div_q  <= ckd_pkg::RST_DIV_CTRL;
      fb_q   <= ckd_pkg::RST_PLLFB;
      trim_q <= ckd_pkg::RST_TRIM;
    end else begin
      div_q  <= div_d;
      fb_q   <= fb_d;
      trim_q <= trim_d;
    end
  end

  // ==========================================================
  // Decoded clock generator controls, registered from next state
  logic [7:0] cpu_div_d;
  logic [7:0] rc_div_d;
  logic [3:0] post_d;
  logic [5:0] pre_d;
  logic [9:0] mult_d;

  always_comb begin
    cpu_div_d = ckd_pkg::DIV_ONE << eff_ratio;
    rc_div_d  = ckd_pkg::DIV_ONE << div_d[ckd_pkg::RCPOST_MSB:ckd_pkg::RCPOST_LSB];
    pre_d     = {1'b0, div_d[ckd_pkg::PRE_MSB:ckd_pkg::PRE_LSB]} + ckd_pkg::PRE_OFFSET;
    mult_d    = {1'b0, fb_d[ckd_pkg::FB_MSB:0]} + ckd_pkg::FB_OFFSET;
    case (div_d[ckd_pkg::POST_MSB:ckd_pkg::POST_LSB])
      ckd_pkg::POST_DIV2: post_d = ckd_pkg::POST_VAL2;
      ckd_pkg::POST_DIV4: post_d = ckd_pkg::POST_VAL4;
      ckd_pkg::POST_DIV8: post_d = ckd_pkg::POST_VAL8;
      default:            post_d = ckd_pkg::POST_INVALID;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      recover_on_interrupt      <= ckd_pkg::RST_DIV_CTRL[ckd_pkg::RECOVER_BIT];
      reduction_enable          <= ckd_pkg::RST_DIV_CTRL[ckd_pkg::REDUCE_EN_BIT];
      cpu_clock_reduction_ratio <= 3'h0;
      cpu_divisor               <= ckd_pkg::DIV_ONE;
      internal_rc_postscaler    <= ckd_pkg::RST_DIV_CTRL[ckd_pkg::RCPOST_MSB:ckd_pkg::RCPOST_LSB];
      rc_post_divisor           <= ckd_pkg::DIV_ONE;
      pll_output_divider        <= ckd_pkg::POST_DIV4;
      postscale_factor          <= ckd_pkg::POST_VAL4;
      pll_input_divider         <= ckd_pkg::RST_DIV_CTRL[ckd_pkg::PRE_MSB:ckd_pkg::PRE_LSB];
      prescale_factor           <= ckd_pkg::PRE_OFFSET;
      pll_feedback_divisor      <= ckd_pkg::RST_PLLFB[ckd_pkg::FB_MSB:0];
      pll_multiplier            <= {1'b0, ckd_pkg::RST_PLLFB[ckd_pkg::FB_MSB:0]} +
                                   ckd_pkg::FB_OFFSET;
      rc_trim_code              <= ckd_pkg::RST_TRIM[ckd_pkg::TRIM_MSB:0];
    end else begin
      recover_on_interrupt      <= div_d[ckd_pkg::RECOVER_BIT];
      reduction_enable          <= div_d[ckd_pkg::REDUCE_EN_BIT];
      cpu_clock_reduction_ratio <= eff_ratio;
      cpu_divisor               <= cpu_div_d;
      internal_rc_postscaler    <= div_d[ckd_pkg::RCPOST_MSB:ckd_pkg::RCPOST_LSB];
      rc_post_divisor           <= rc_div_d;
      pll_output_divider        <= div_d[ckd_pkg::POST_MSB:ckd_pkg::POST_LSB];
      postscale_factor          <= post_d;
      pll_input_divider         <= div_d[ckd_pkg::PRE_MSB:ckd_pkg::PRE_LSB];
      prescale_factor           <= pre_d;
      pll_feedback_divisor      <= fb_d[ckd_pkg::FB_MSB:0];
      pll_multiplier            <= mult_d;
      // Two's complement code goes straight to the trim DAC
      rc_trim_code              <= trim_d[ckd_pkg::TRIM_MSB:0];
    end
  end

  // ==========================================================
  // APB answer: no wait state, with pready registered from setup so all bus outputs come from flops
  logic [31:0] rdata_d;
  logic        ready_d;
  logic        err_d;

  always_comb begin
    rdata_d = prdata;
    ready_d = setup;
    err_d   = 1'b0;
    if (setup) begin
      rdata_d = 32'h0000_0000;
      if (hit_div) begin
        rdata_d[15:0] = div_q;
      end else if (hit_fb) begin
        rdata_d[15:0] = fb_q & ckd_pkg::MASK_PLLFB;
      end else if (hit_trim) begin
        rdata_d[15:0] = trim_q & ckd_pkg::MASK_TRIM;
      end else begin
        err_d = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= rdata_d;
      pready  <= ready_d;
      pslverr <= err_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence setup_s;
    psel && !penable;
  endsequence

  sequence write_fb_s;
    psel && penable && pready && pwrite && hit_fb;
  endsequence

  sequence read_s(logic hit);
    setup_s ##1 (psel && penable && hit && !pwrite);
  endsequence

  irq_recover_a: assert property (irq_event && recover_on_interrupt && !wr_en |=>
    !reduction_enable && cpu_divisor == ckd_pkg::DIV_ONE)
    else $error("interrupt did not cancel clock reduction");

  irq_ignore_a: assert property (irq_event && !div_q[ckd_pkg::RECOVER_BIT] && !wr_en |=>
    $stable(reduction_enable))
    else $error("interrupt changed reduction without recovery set");

  cpu_ratio_a: assert property (reduction_enable |->
    cpu_divisor == (ckd_pkg::DIV_ONE << cpu_clock_reduction_ratio))
    else $error("processor divisor is not a power of two of the code");

  ratio_off_a: assert property (!reduction_enable |->
    cpu_divisor == ckd_pkg::DIV_ONE && cpu_clock_reduction_ratio == 3'h0)
    else $error("ratio not 1:1 while reduction disabled");

  rc_div_a: assert property (rc_post_divisor ==
    (ckd_pkg::DIV_ONE << internal_rc_postscaler))
    else $error("RC postscaler divisor wrong");

  post_div_a: assert property ((pll_output_divider == ckd_pkg::POST_DIV8) ==
    (postscale_factor == ckd_pkg::POST_VAL8))
    else $error("PLL output divider decode wrong");

  pre_div_a: assert property (
    prescale_factor == {1'b0, pll_input_divider} + ckd_pkg::PRE_OFFSET)
    else $error("PLL input divider is not code plus two");

  fb_write_a: assert property (write_fb_s |=>
    pll_multiplier == {1'b0, $past(pwdata[8:0])} + ckd_pkg::FB_OFFSET)
    else $error("PLL multiplier is not written code plus two");

  fb_read_a: assert property (read_s(hit_fb) |-> prdata[15:9] == 7'h00)
    else $error("feedback register upper bits not zero");

  trim_read_a: assert property (read_s(hit_trim) |-> prdata[15:6] == 10'h000)
    else $error("trim register upper bits not zero");

  trim_out_a: assert property (wr_en && hit_trim |=>
    rc_trim_code == $past(pwdata[5:0]))
    else $error("trim code not presented after write");

  trim_keep_a: assert property (!(wr_en && hit_trim) |=> $stable(rc_trim_code))
    else $error("trim code changed without a write");

  reset_vals_a: assert property ($rose(reset_n) |->
    pll_multiplier == 10'h032 && postscale_factor == ckd_pkg::POST_VAL4)
    else $error("reset defaults wrong");

  div_write_a: assert property (wr_en && hit_div && !irq_event |=>
    pll_input_divider == $past(pwdata[4:0]) && internal_rc_postscaler == $past(pwdata[10:8]))
    else $error("divider write not presented next cycle");

  wait_state_a: assert property (setup_s |=> pready)
    else $error("slave did not answer in access phase");

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready stood longer than one cycle");

  err_unmapped_a: assert property (psel && !penable && !(hit_div || hit_fb || hit_trim) |=>
    pready && pslverr)
    else $error("unmapped access not refused");

  err_mapped_a: assert property (psel && !penable && (hit_div || hit_fb || hit_trim) |=>
    pready && !pslverr)
    else $error("mapped access refused");

  // Recovery must win even when software sets the enable in the same edge
  irq_wins_a: assert property (
    wr_en && hit_div && irq_event && pwdata[ckd_pkg::RECOVER_BIT] |=> !reduction_enable)
    else $error("interrupt lost against a same-cycle write");

  post_rsvd_a: assert property (pll_output_divider == ckd_pkg::POST_RESERVED |->
    postscale_factor == ckd_pkg::POST_INVALID)
    else $error("reserved output divider code not flagged");

  post_four_a: assert property ((pll_output_divider == ckd_pkg::POST_DIV4) ==
    (postscale_factor == ckd_pkg::POST_VAL4))
    else $error("default output divider decode wrong");

  div_read_a: assert property (read_s(hit_div) |->
    prdata[31:16] == 16'h0000 && (prdata[15:0] & ~ckd_pkg::MASK_DIV_CTRL) == 16'h0000)
    else $error("divider register unimplemented bit not zero");

  mult_keep_a: assert property (!(wr_en && hit_fb) |=> $stable(pll_multiplier))
    else $error("multiplier changed without a write");

endmodule

`default_nettype wire

// >>> tb.sv
// Self-checking testbench for the clock divider, PLL and RC trim registers.
// Assumes ckd_pkg and ckd_regs are compiled first; one clock, APB master in the bench.
`timescale 1ns/1ns
`default_nettype none

module tb;
  // ==========================================================
  // Stimulus and observed signals
  logic        core_clk  = 1'b0;
  logic        reset_n   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic        irq_event = 1'b0;
  logic [31:0] prdata;
  logic        pready, pslverr, recover_on_interrupt, reduction_enable;
  logic [2:0]  cpu_clock_reduction_ratio, internal_rc_postscaler;
  logic [7:0]  cpu_divisor, rc_post_divisor;
  logic [1:0]  pll_output_divider;
  logic [3:0]  postscale_factor;
  logic [4:0]  pll_input_divider;
  logic [5:0]  prescale_factor, rc_trim_code;
  logic [8:0]  pll_feedback_divisor;
  logic [9:0]  pll_multiplier;
  int          errors = 0;
  int          comparisons = 0;
  int          seed = 32'h7C42;
  logic [15:0] m_cd, m_fb, m_tr;
  logic [11:0] addrs [3] = '{ckd_pkg::ADDR_DIV_CTRL, ckd_pkg::ADDR_PLLFB, ckd_pkg::ADDR_TRIM};

  always #25 core_clk = ~core_clk;

  ckd_regs i_ckd_regs (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_event(irq_event),
    .recover_on_interrupt(recover_on_interrupt), .reduction_enable(reduction_enable),
    .cpu_clock_reduction_ratio(cpu_clock_reduction_ratio), .cpu_divisor(cpu_divisor),
    .internal_rc_postscaler(internal_rc_postscaler), .rc_post_divisor(rc_post_divisor),
    .pll_output_divider(pll_output_divider), .postscale_factor(postscale_factor),
    .pll_input_divider(pll_input_divider), .prescale_factor(prescale_factor),
    .pll_feedback_divisor(pll_feedback_divisor), .pll_multiplier(pll_multiplier),
    .rc_trim_code(rc_trim_code));

  // ==========================================================
  // Checking and bus tasks
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  function automatic logic [31:0] post_f(input logic [1:0] c);
    case (c)
      2'h0:    return 32'h2;
      2'h1:    return 32'h4;
      2'h3:    return 32'h8;
      default: return 32'h0;
    endcase
  endfunction

  // Entered just after a rising edge; leaves one idle edge so psel is never set twice at once
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Ends when pready is seen high; the watchdog ends it if pready never rises
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task wr(input logic [11:0] a, input logic [15:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, {16'hA5A5, d}, r, e);
    if (a == ckd_pkg::ADDR_DIV_CTRL) m_cd = d & ckd_pkg::MASK_DIV_CTRL;
    else if (a == ckd_pkg::ADDR_PLLFB) m_fb = d & ckd_pkg::MASK_PLLFB;
    else m_tr = d & ckd_pkg::MASK_TRIM;
  endtask

  task check_all;
    logic [31:0] r;
    logic        e;
    logic [2:0]  eff;
    eff = m_cd[11] ? m_cd[14:12] : 3'h0;
    chk("ratio", 32'(cpu_clock_reduction_ratio), 32'(eff));
    chk("cpu_div", 32'(cpu_divisor), 32'h1 << eff);
    chk("recover", 32'(recover_on_interrupt), 32'(m_cd[15]));
    chk("reduce_en", 32'(reduction_enable), 32'(m_cd[11]));
    chk("rc_div", 32'(rc_post_divisor), 32'h1 << m_cd[10:8]);
    chk("rc_code", 32'(internal_rc_postscaler), 32'(m_cd[10:8]));
    chk("post_code", 32'(pll_output_divider), 32'(m_cd[7:6]));
    chk("pre_code", 32'(pll_input_divider), 32'(m_cd[4:0]));
    chk("fb_code", 32'(pll_feedback_divisor), 32'(m_fb[8:0]));
    chk("post", 32'(postscale_factor), post_f(m_cd[7:6]));
    chk("pre", 32'(prescale_factor), 32'(m_cd[4:0]) + 32'h2);
    chk("mult", 32'(pll_multiplier), 32'(m_fb[8:0]) + 32'h2);
    chk("trim", 32'(rc_trim_code), 32'(m_tr[5:0]));
    apb(1'b0, ckd_pkg::ADDR_DIV_CTRL, 32'h0, r, e);
    chk("cd_rd", r, {16'h0, m_cd});
    chk("cd_err", 32'(e), 32'h0);
    apb(1'b0, ckd_pkg::ADDR_PLLFB, 32'h0, r, e);
    chk("fb_rd", r, {16'h0, m_fb});
    chk("fb_err", 32'(e), 32'h0);
    apb(1'b0, ckd_pkg::ADDR_TRIM, 32'h0, r, e);
    chk("tr_rd", r, {16'h0, m_tr});
  endtask

  task irq_pulse;
    irq_event <= 1'b1;
    @(posedge core_clk);
    irq_event <= 1'b0;
    @(posedge core_clk);
  endtask

  // ==========================================================
  // Watchdog: the run needs a few thousand cycles at most
  initial begin
    #500000;
    errors++;
    complete_run;
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] r, d;
    logic        e;
    m_cd = ckd_pkg::RST_DIV_CTRL;
    m_fb = ckd_pkg::RST_PLLFB;
    m_tr = ckd_pkg::RST_TRIM;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    check_all;
    wr(ckd_pkg::ADDR_DIV_CTRL, 16'hFFFF); check_all;
    wr(ckd_pkg::ADDR_DIV_CTRL, 16'h0080); check_all;
    wr(ckd_pkg::ADDR_PLLFB, 16'hFFFF); check_all;
    wr(ckd_pkg::ADDR_TRIM, 16'h001F); check_all;
    wr(ckd_pkg::ADDR_TRIM, 16'hFFFF); check_all;
    // Unmapped place: refused, nothing stored
    apb(1'b1, 12'h00C, 32'hFFFF, r, e);
    chk("bad_wr_err", 32'(e), 32'h1);
    apb(1'b0, 12'h00C, 32'h0, r, e);
    chk("bad_rd", r, 32'h0);
    check_all;
    // Interrupt recovery with and without the recover bit
    wr(ckd_pkg::ADDR_DIV_CTRL, 16'hB800);
    irq_pulse;
    m_cd[11] = 1'b0;
    check_all;
    wr(ckd_pkg::ADDR_DIV_CTRL, 16'h3800);
    irq_pulse;
    check_all;
    // Interrupt at the very edge of a write that sets the enable: recovery wins
    fork
      wr(ckd_pkg::ADDR_DIV_CTRL, 16'h9800);
      begin
        @(posedge core_clk);
        irq_event <= 1'b1;
        @(posedge core_clk);
        irq_event <= 1'b0;
      end
    join
    m_cd[11] = 1'b0;
    check_all;
    for (int i = 0; i < 60; i++) begin
      d = $random(seed);
      wr(addrs[d[17:16] % 3], d[15:0]);
      check_all;
    end
    // Reset in mid-run brings back the defaults
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    m_cd = ckd_pkg::RST_DIV_CTRL;
    m_fb = ckd_pkg::RST_PLLFB;
    m_tr = ckd_pkg::RST_TRIM;
    check_all;
    complete_run;
  end
endmodule

`default_nettype wire
